//--- logic/lbr_pkg.sv
`default_nettype none
package lbr_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  SPACE2_BRD_OFFSET = 8'h30;
  localparam logic [31:0] SPACE2_BRD_RESET  = 32'h0080_0000;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BURST_EN_BIT   = 0;
  localparam int READY_EN_BIT   = 1;
  localparam int BURST_TERMINATE_IN_N_EN_BIT   = 2;
  localparam int PF_COUNT_LSB   = 3;
  localparam int PF_EN_BIT      = 5;
  localparam int RAD_LSB        = 6;
  localparam int RDD_LSB        = 11;
  localparam int XDA_LSB        = 13;
  localparam int WAD_LSB        = 15;
  localparam int WDD_LSB        = 20;
  localparam int WIDTH_LSB      = 22;
  localparam int BIG_ENDIAN_BIT = 24;
  localparam int UPPER_LANE_BIT = 25;
  localparam int RD_DELAY_LSB   = 26;
  localparam int WR_DELAY_LSB   = 28;
  localparam int WR_HOLD_LSB    = 30;
  // ----------------------------------------------------------------
  // Encodings and counts
  // ----------------------------------------------------------------
  localparam logic [1:0] WIDTH_8  = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;
  localparam logic [4:0] NO_BURST_TERMINATE_IN_N_MAX_BEATS = 5'h04;
  localparam logic [4:0] PF_BEATS_01 = 5'h04;
  localparam logic [4:0] PF_BEATS_10 = 5'h08;
  localparam logic [4:0] PF_BEATS_11 = 5'h10;
  localparam logic [4:0] BEAT_SAT    = 5'h1f;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_WAD  = 3'b010,
    ST_DATA = 3'b011,
    ST_DD   = 3'b100,
    ST_HOLD = 3'b101,
    ST_XDA  = 3'b110
  } cyc_state_e;
endpackage
`default_nettype wire

//--- logic/local_space2_bus_region_config.sv
// Notes on behaviour
// - Burst only with burst enable and nonzero prefetch.
// - Bit 1 enables waiting on local ready.
// - Terminate input disabled limits bursts to four.
// - Prefetch count field selects none, 4, 8, 16.
// - Count disabled: prefetch until host stops.
// - Read address-to-data waits, 0 to 31.
// - Read data-to-data waits between burst beats.
// - Data-to-address waits float the write data.
// - Write address-to-data waits hold data valid.
// - Write data-to-data waits between burst beats.
// - Width field 8/16/32, resets to 32.
// - Bit 24 selects big or little endian.
// - Bit 25 places narrow big endian lanes.
// - Read strobe after delay, only if delay within waits.
// - Write strobe after delay, only if delay within waits.
// - Write hold clocks extend cycle after strobe.
//
// Design decision made here: the address-and-strobe port.
`default_nettype none
module local_space2_bus_region_config (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [31:0] reg_rdata,
  input  wire logic        req_start,
  input  wire logic        req_write,
  input  wire logic [31:0] req_addr,
  input  wire logic [31:0] req_wdata,
  input  wire logic [4:0]  req_beats,
  input  wire logic        host_stop,
  output logic             busy,
  output logic             beat_done,
  output logic             done,
  output logic      [31:0] rdata,
  input  wire logic [31:0] local_addr_data_bus_in,
  output logic      [31:0] local_addr_data_bus_out,
  output logic             local_addr_data_bus_oe,
  output logic             addr_strobe,
  output logic             read_strobe_n,
  output logic             write_strobe_n,
  input  wire logic        local_ready_in_n,
  input  wire logic        burst_terminate_in_n
);
  // ----------------------------------------------------------------
  // Register
  // ----------------------------------------------------------------
  logic [31:0] space2_bus_region_descriptor;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      space2_bus_region_descriptor <= lbr_pkg::SPACE2_BRD_RESET;
    end else if (reg_write && reg_addr == lbr_pkg::SPACE2_BRD_OFFSET) begin
      space2_bus_region_descriptor <= reg_wdata;
    end
  end
  // Read data stands for exactly one cycle; unmapped reads return zero.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_read && reg_addr == lbr_pkg::SPACE2_BRD_OFFSET) begin
      reg_rdata <= space2_bus_region_descriptor;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end
  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  logic [31:0] cfg;
  logic       burst_en, ready_en, burst_terminate_in_n_en, pf_en, big_endian, upper_lane;
  logic [1:0] pf_count, width, rdd, xda, wdd, rd_delay, wr_delay, wr_hold;
  logic [4:0] rad, wad;
  assign cfg        = space2_bus_region_descriptor;
  assign burst_en   = cfg[lbr_pkg::BURST_EN_BIT];
  assign ready_en   = cfg[lbr_pkg::READY_EN_BIT];
  assign burst_terminate_in_n_en   = cfg[lbr_pkg::BURST_TERMINATE_IN_N_EN_BIT];
  assign pf_en      = cfg[lbr_pkg::PF_EN_BIT];
  assign big_endian = cfg[lbr_pkg::BIG_ENDIAN_BIT];
  assign upper_lane = cfg[lbr_pkg::UPPER_LANE_BIT];
  assign pf_count   = cfg[lbr_pkg::PF_COUNT_LSB +: 2];
  assign width      = cfg[lbr_pkg::WIDTH_LSB +: 2];
  assign rdd        = cfg[lbr_pkg::RDD_LSB +: 2];
  assign xda        = cfg[lbr_pkg::XDA_LSB +: 2];
  assign wdd        = cfg[lbr_pkg::WDD_LSB +: 2];
  assign rd_delay   = cfg[lbr_pkg::RD_DELAY_LSB +: 2];
  assign wr_delay   = cfg[lbr_pkg::WR_DELAY_LSB +: 2];
  assign wr_hold    = cfg[lbr_pkg::WR_HOLD_LSB +: 2];
  assign rad        = cfg[lbr_pkg::RAD_LSB +: 5];
  assign wad        = cfg[lbr_pkg::WAD_LSB +: 5];

  // ----------------------------------------------------------------
  // Byte lane placement
  // ----------------------------------------------------------------
  // The same mapping serves both directions: a narrow port only ever uses
  // one lane group, so extraction is the mirror of placement.
  function automatic logic [31:0] to_lanes(input logic [31:0] w);
    logic [31:0] r;
    r = w;
    if (big_endian) begin
      if (width == lbr_pkg::WIDTH_8) begin
        r = upper_lane ? {w[7:0], 24'h000000} : {24'h000000, w[7:0]};
      end else if (width == lbr_pkg::WIDTH_16) begin
        r = upper_lane ? {w[7:0], w[15:8], 16'h0000} : {16'h0000, w[7:0], w[15:8]};
      end else begin
        r = {w[7:0], w[15:8], w[23:16], w[31:24]};
      end
    end
    return r;
  endfunction
  function automatic logic [31:0] from_lanes(input logic [31:0] b);
    logic [31:0] r;
    r = b;
    if (big_endian) begin
      if (width == lbr_pkg::WIDTH_8) begin
        r = {24'h000000, upper_lane ? b[31:24] : b[7:0]};
      end else if (width == lbr_pkg::WIDTH_16) begin
        r = upper_lane ? {16'h0000, b[23:16], b[31:24]} : {16'h0000, b[7:0], b[15:8]};
      end else begin
        r = {b[7:0], b[15:8], b[23:16], b[31:24]};
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Cycle engine
  // ----------------------------------------------------------------
  // Every count below ticks on clk_sys, which is the local bus clock.
  lbr_pkg::cyc_state_e state, next_state;
  logic [5:0]  cnt, next_cnt;
  logic [4:0]  beat, next_beat, limit, pf_len, ad_waits;
  logic [1:0]  dd_waits, strobe_delay;
  logic        wr, next_wr, unlimited, burst_ok, beat_ok, last, strobe_ok;
  logic [31:0] addr_q;

  // At the start edge the stored direction is stale, so the request picks the fields.
  assign next_wr      = (state == lbr_pkg::ST_IDLE) ? req_write : wr;
  assign ad_waits     = next_wr ? wad : rad;
  assign dd_waits     = next_wr ? wdd : rdd;
  assign strobe_delay = next_wr ? wr_delay : rd_delay;
  assign strobe_ok    = {3'h0, strobe_delay} <= ad_waits;
  assign burst_ok     = burst_en && pf_count != 2'h0;
  assign beat_ok      = state == lbr_pkg::ST_DATA && (!ready_en || !local_ready_in_n);

  always_comb begin
    case (pf_count)
      2'h1:    pf_len = lbr_pkg::PF_BEATS_01;
      2'h2:    pf_len = lbr_pkg::PF_BEATS_10;
      2'h3:    pf_len = lbr_pkg::PF_BEATS_11;
      default: pf_len = 5'h01;
    endcase
  end
  // Writes take their length from the requester; reads from the prefetch setup.
  always_comb begin
    unlimited = 1'b0;
    if (!burst_ok) begin
      limit = 5'h01;
    end else if (wr) begin
      limit = (req_beats == 5'h00) ? 5'h01 : req_beats;
    end else if (pf_en) begin
      limit = pf_len;
    end else begin
      limit     = lbr_pkg::BEAT_SAT;
      unlimited = 1'b1;
    end
    if (!burst_terminate_in_n_en && limit > lbr_pkg::NO_BURST_TERMINATE_IN_N_MAX_BEATS) begin
      limit     = lbr_pkg::NO_BURST_TERMINATE_IN_N_MAX_BEATS;
      unlimited = 1'b0;
    end
  end
  assign last = (beat + 5'h01 >= limit && !unlimited)
             || (burst_terminate_in_n_en && !burst_terminate_in_n)
             || (unlimited && host_stop);

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_beat  = beat;
    case (state)
      lbr_pkg::ST_IDLE: begin
        next_cnt  = 6'h00;
        next_beat = 5'h00;
        if (req_start) begin
          next_state = lbr_pkg::ST_ADDR;
        end
      end
      lbr_pkg::ST_ADDR, lbr_pkg::ST_WAD: begin
        if (cnt >= {1'b0, ad_waits}) begin
          next_state = lbr_pkg::ST_DATA;
        end else begin
          next_state = lbr_pkg::ST_WAD;
          next_cnt   = cnt + 6'h01;
        end
      end
      lbr_pkg::ST_DATA: begin
        if (beat_ok) begin
          next_cnt = 6'h00;
          if (beat != lbr_pkg::BEAT_SAT) begin
            next_beat = beat + 5'h01;
          end
          if (!last) begin
            next_state = (dd_waits != 2'h0) ? lbr_pkg::ST_DD : lbr_pkg::ST_DATA;
          end else if (wr && wr_hold != 2'h0) begin
            next_state = lbr_pkg::ST_HOLD;
          end else if (xda != 2'h0) begin
            next_state = lbr_pkg::ST_XDA;
          end else begin
            next_state = lbr_pkg::ST_IDLE;
          end
        end
      end
      lbr_pkg::ST_DD: begin
        next_cnt = cnt + 6'h01;
        if (cnt + 6'h01 >= {4'h0, dd_waits}) begin
          next_state = lbr_pkg::ST_DATA;
          next_cnt   = 6'h00;
        end
      end
      lbr_pkg::ST_HOLD: begin
        next_cnt = cnt + 6'h01;
        if (cnt + 6'h01 >= {4'h0, wr_hold}) begin
          next_cnt   = 6'h00;
          next_state = (xda != 2'h0) ? lbr_pkg::ST_XDA : lbr_pkg::ST_IDLE;
        end
      end
      lbr_pkg::ST_XDA: begin
        next_cnt = cnt + 6'h01;
        if (cnt + 6'h01 >= {4'h0, xda}) begin
          next_state = lbr_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = lbr_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state <= lbr_pkg::ST_IDLE;
      cnt   <= 6'h00;
      beat  <= 5'h00;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      beat  <= next_beat;
    end
  end
  // Direction and address are frozen at the start so the fields stay coherent.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wr     <= 1'b0;
      addr_q <= 32'h0000_0000;
    end else if (state == lbr_pkg::ST_IDLE && req_start) begin
      wr     <= req_write;
      addr_q <= req_addr;
    end
  end

  // ----------------------------------------------------------------
  // Registered pin and status outputs
  // ----------------------------------------------------------------
  logic next_strobe, next_oe;
  assign next_strobe = strobe_ok && (next_state == lbr_pkg::ST_DATA
                    || ((next_state == lbr_pkg::ST_ADDR || next_state == lbr_pkg::ST_WAD)
                        && next_cnt >= {4'h0, strobe_delay}));
  // Write data drives through address waits, beats and hold, never in XDA.
  assign next_oe = next_state == lbr_pkg::ST_ADDR
                || (next_wr && (next_state == lbr_pkg::ST_WAD || next_state == lbr_pkg::ST_DATA
                    || next_state == lbr_pkg::ST_DD || next_state == lbr_pkg::ST_HOLD));

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      local_addr_data_bus_out <= 32'h0000_0000;
      local_addr_data_bus_oe  <= 1'b0;
      addr_strobe             <= 1'b0;
      read_strobe_n           <= 1'b1;
      write_strobe_n          <= 1'b1;
    end else begin
      local_addr_data_bus_out <= (next_state == lbr_pkg::ST_ADDR)
                               ? ((state == lbr_pkg::ST_IDLE) ? req_addr : addr_q)
                               : to_lanes(req_wdata);
      local_addr_data_bus_oe  <= next_oe;
      addr_strobe             <= next_state == lbr_pkg::ST_ADDR;
      read_strobe_n           <= !(next_strobe && !next_wr);
      write_strobe_n          <= !(next_strobe && next_wr);
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      busy      <= 1'b0;
      beat_done <= 1'b0;
      done      <= 1'b0;
      rdata     <= 32'h0000_0000;
    end else begin
      busy      <= next_state != lbr_pkg::ST_IDLE;
      beat_done <= beat_ok;
      done      <= state != lbr_pkg::ST_IDLE && next_state == lbr_pkg::ST_IDLE;
      if (beat_ok && !wr) begin
        rdata <= from_lanes(local_addr_data_bus_in);
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_beat_end;
    beat_ok && last;
  endsequence
  sequence s_after_write_end;
    (state == lbr_pkg::ST_HOLD || state == lbr_pkg::ST_XDA || state == lbr_pkg::ST_IDLE);
  endsequence
  a_single_beat: assert property (@(posedge clk_sys) disable iff (!rst_b)
    beat_ok && !burst_ok |-> last ##1 s_after_write_end) else $error("burst without enable");
  a_ready_wait: assert property (@(posedge clk_sys) disable iff (!rst_b)
    state == lbr_pkg::ST_DATA && ready_en && local_ready_in_n |=> state == lbr_pkg::ST_DATA)
    else $error("ready input ignored");
  a_burst_terminate_in_n_limit: assert property (@(posedge clk_sys) disable iff (!rst_b)
    state == lbr_pkg::ST_DATA && !burst_terminate_in_n_en |-> beat < 5'h04) else $error("burst over four");
  a_pf_limit: assert property (@(posedge clk_sys) disable iff (!rst_b)
    state == lbr_pkg::ST_DATA && !wr && burst_ok && pf_en |-> beat < pf_len)
    else $error("prefetch over count");
  a_ad_waits: assert property (@(posedge clk_sys) disable iff (!rst_b)
    state == lbr_pkg::ST_WAD |-> cnt <= {1'b0, ad_waits} && cnt != 6'h00)
    else $error("address wait count wrong");
  a_dd_waits: assert property (@(posedge clk_sys) disable iff (!rst_b)
    beat_ok && !last && dd_waits == 2'h2 |=> state == lbr_pkg::ST_DD [*2] ##1
    state == lbr_pkg::ST_DATA) else $error("data wait count wrong");
  a_xda_float: assert property (@(posedge clk_sys) disable iff (!rst_b)
    state == lbr_pkg::ST_XDA |-> !local_addr_data_bus_oe) else $error("data driven in xda");
  a_wad_data: assert property (@(posedge clk_sys) disable iff (!rst_b)
    state == lbr_pkg::ST_WAD && wr |-> local_addr_data_bus_oe) else $error("write data gap");
  a_width_reset: assert property (@(posedge clk_sys)
    $rose(rst_b) |-> cfg[lbr_pkg::WIDTH_LSB +: 2] == 2'h2) else $error("width reset wrong");
  a_rd_strobe: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!wr && !strobe_ok) || state == lbr_pkg::ST_IDLE || state == lbr_pkg::ST_XDA
    |-> read_strobe_n) else $error("read strobe misplaced");
  a_wr_strobe: assert property (@(posedge clk_sys) disable iff (!rst_b)
    state == lbr_pkg::ST_ADDR && wr && strobe_ok && wr_delay == 2'h0 |-> !write_strobe_n)
    else $error("write strobe late");
  a_hold_data: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_beat_end and (wr && wr_hold != 2'h0) |=> state == lbr_pkg::ST_HOLD
    && write_strobe_n && local_addr_data_bus_oe) else $error("write hold wrong");
endmodule
`default_nettype wire

//--- dv/local_peripheral_model.sv
`default_nettype none
module local_peripheral_model (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        addr_strobe,
  input  wire logic        read_strobe_n,
  input  wire logic        write_strobe_n,
  input  wire logic [31:0] rd_word,
  input  wire logic [7:0]  rdy_wait,
  input  wire logic        term_cmd,
  output logic      [31:0] bus_in,
  output logic             ready_n,
  output logic             term_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  cnt;
  logic [31:0] last;
  // ----------------------------------------------------------------
  // Slow or prompt peripheral
  // ----------------------------------------------------------------
  // A released bus flips every cycle, so a late sample cannot pass.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt  <= 8'h00;
      last <= 32'h0;
    end else begin
      cnt  <= addr_strobe ? 8'h00 : cnt + 8'h01;
      last <= bus_in;
    end
  end
  assign bus_in  = !read_strobe_n ? rd_word : ~last;
  assign ready_n = !(cnt >= rdy_wait);
  assign term_n  = !(term_cmd && !(read_strobe_n && write_strobe_n));
endmodule
`default_nettype wire

//--- dv/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys, rst_b, reg_write, reg_read, req_start, req_write, host_stop;
  logic        busy, beat_done, done, bus_oe, addr_strobe, read_strobe_n;
  logic        write_strobe_n, ready_n, term_n, term_cmd;
  logic [7:0]  reg_addr, rdy_wait;
  logic [4:0]  req_beats;
  logic [31:0] reg_wdata, reg_rdata, req_addr, req_wdata, rdata;
  logic [31:0] bus_in, bus_out, rd_word, cap, adr;
  int          fail_count, compares, cyc, t_cnt, nb, n_str, n_oe, n_busy;
  local_space2_bus_region_config DUT (.clk_sys(clk_sys), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .req_start(req_start),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_beats(req_beats), .host_stop(host_stop), .busy(busy), .beat_done(beat_done),
    .done(done), .rdata(rdata), .local_addr_data_bus_in(bus_in),
    .local_addr_data_bus_out(bus_out), .local_addr_data_bus_oe(bus_oe),
    .addr_strobe(addr_strobe), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .local_ready_in_n(ready_n),
    .burst_terminate_in_n(term_n));
  local_peripheral_model peer (.clk_sys(clk_sys), .rst_b(rst_b),
    .addr_strobe(addr_strobe), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .rd_word(rd_word), .rdy_wait(rdy_wait),
    .term_cmd(term_cmd), .bus_in(bus_in), .ready_n(ready_n), .term_n(term_n));
  // ----------------------------------------------------------------
  // Common tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1;
    chk(reg_rdata, exp, "register read");
  endtask
  function automatic logic [31:0] cfg_word(int b, rd, bt, pf, pe, rad, rdd, xda, wad,
                                           wdd, w, be, up, rdl, wdl, h);
    cfg_word = {h[1:0], wdl[1:0], rdl[1:0], up[0], be[0], w[1:0], wdd[1:0], wad[4:0],
                xda[1:0], rdd[1:0], rad[4:0], pe[0], pf[1:0], bt[0], rd[0], b[0]};
  endfunction
  // Counts beats, busy, strobe and drive cycles of one local cycle; cycle 1 is the address phase.
  task automatic go(input logic [31:0] c, input int wr, nq, st, et, enb, ens, eno);
    reg_wr(lbr_pkg::SPACE2_BRD_OFFSET, c);
    {t_cnt, nb, n_str, n_oe, n_busy} = '0;
    @(posedge clk_sys);
    req_start <= 1'b1;
    req_write <= wr[0];
    req_beats <= nq[4:0];
    @(posedge clk_sys);
    req_start <= 1'b0;
    while (t_cnt < 300) begin
      #1;
      t_cnt++;
      if (beat_done === 1'b1) nb++;
      if (busy === 1'b1) n_busy++;
      if ((wr ? write_strobe_n : read_strobe_n) === 1'b0) n_str++;
      if (bus_oe === 1'b1) n_oe++;
      if (addr_strobe === 1'b1) adr = bus_out;
      if (wr && bus_oe === 1'b1 && addr_strobe === 1'b0) cap = bus_out;
      if (!wr && beat_done === 1'b1) cap = rdata;
      if (done === 1'b1) break;
      @(posedge clk_sys);
      host_stop <= (nb >= st);
      term_cmd  <= (nb >= st);
    end
    host_stop <= 1'b0;
    term_cmd  <= 1'b0;
    chk(t_cnt, et, "cycle length");
    chk(nb, enb, "beat count");
    chk(n_busy, t_cnt - 1, "busy length");
    chk(adr, req_addr, "address phase");
    if (ens >= 0) chk(n_str, ens, "strobe length");
    if (eno >= 0) chk(n_oe, eno, "drive length");
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    reg_rd(8'h30, 32'h0080_0000);
    reg_wr(8'h30, 32'hffff_ffff);
    reg_rd(8'h30, 32'hffff_ffff);
    reg_wr(8'h34, 32'h0);
    reg_rd(8'h30, 32'hffff_ffff);
    reg_rd(8'h34, 32'h0);
  endtask
  task automatic t_reads();
    go(cfg_word(0,0,0,3,1,3,0,0,0,0,2,0,0,2,0,0), 0, 1, 99, 6, 1, 3, 1);
    go(cfg_word(0,0,0,0,0,2,0,0,0,0,2,0,0,3,0,0), 0, 1, 99, 5, 1, 0, 1);
    go(cfg_word(0,1,0,0,0,3,0,0,0,0,2,0,0,0,0,0), 0, 1, 99, 8, 1, -1, 1);
    go(cfg_word(0,0,0,0,0,31,0,0,0,0,2,0,0,3,0,0), 0, 1, 99, 34, 1, 30, 1);
  endtask
  task automatic t_bursts();
    for (int p = 1; p < 4; p++) begin
      go(cfg_word(1,0,1,p,1,0,1,2,0,0,2,0,0,0,0,0), 0, 1, 99, 3 + 8 * (1 << (p - 1)),
         4 * (1 << (p - 1)), -1, 1);
    end
    go(cfg_word(1,0,0,3,1,0,1,2,0,0,2,0,0,0,0,0), 0, 1, 99, 11, 4, -1, 1);
    go(cfg_word(1,0,1,3,1,0,1,2,0,0,2,0,0,0,0,0), 0, 1, 1, 7, 2, -1, 1);
    // Strobe kept off so the terminate input stays quiet and only host stop ends it.
    go(cfg_word(1,0,1,1,0,0,1,2,0,0,2,0,0,3,0,0), 0, 1, 1, 7, 2, 0, 1);
    go(cfg_word(1,0,1,0,1,0,1,2,0,0,2,0,0,0,0,0), 0, 1, 99, 5, 1, -1, 1);
  endtask
  task automatic t_writes();
    go(cfg_word(0,0,1,0,0,0,0,1,2,2,2,0,0,0,1,2), 1, 1, 99, 8, 1, 3, 6);
    go(cfg_word(0,0,1,0,0,0,0,1,2,2,2,0,0,0,3,1), 1, 1, 99, 7, 1, 0, 5);
    go(cfg_word(1,0,1,1,1,0,0,1,2,2,2,0,0,0,1,2), 1, 3, 99, 14, 3, -1, 12);
    go(cfg_word(1,0,0,1,1,0,0,1,2,2,2,0,0,0,1,2), 1, 6, 99, 17, 4, -1, 15);
    go(cfg_word(0,0,1,0,0,0,0,3,31,0,2,0,0,0,0,3), 1, 1, 99, 40, 1, 33, 36);
  endtask
  task automatic t_lanes();
    int          w  [6] = '{2, 2, 1, 1, 0, 0};
    int          be [6] = '{0, 1, 1, 1, 1, 1};
    int          up [6] = '{0, 0, 1, 0, 1, 0};
    logic [31:0] m  [6] = '{32'hffffffff, 32'hffffffff, 32'hffff0000, 32'h0000ffff,
                            32'hff000000, 32'h000000ff};
    logic [31:0] e  [6] = '{32'h11223344, 32'h44332211, 32'h44330000, 32'h00004433,
                            32'h44000000, 32'h00000044};
    for (int i = 0; i < 6; i++) begin
      go(cfg_word(0,0,0,0,0,0,0,0,0,0,w[i],be[i],up[i],0,0,0), 1, 1, 99, 3, 1, 2, 2);
      chk(cap & m[i], e[i], "write lanes");
    end
    go(cfg_word(0,0,0,0,0,0,0,0,0,0,2,0,0,0,0,0), 0, 1, 99, 3, 1, 2, 1);
    chk(cap, 32'h11223344, "little endian read");
    go(cfg_word(0,0,0,0,0,0,0,0,0,0,2,1,0,0,0,0), 0, 1, 99, 3, 1, 2, 1);
    chk(cap, 32'h44332211, "big endian read");
  endtask
  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // The whole run needs well under a thousand cycles.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      $display("unexpected at %0t: run did not finish", $time);
      give_verdict();
    end
  end
  initial begin
    {rst_b, reg_write, reg_read, req_start, req_write, host_stop, term_cmd} = '0;
    {reg_addr, reg_wdata, req_beats, cap, adr} = '0;
    {fail_count, compares} = '0;
    req_addr  = 32'h0000_a5c0;
    req_wdata = 32'h1122_3344;
    rd_word   = 32'h1122_3344;
    rdy_wait  = 8'h05;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_regs();
    t_reads();
    t_bursts();
    t_writes();
    t_lanes();
    give_verdict();
  end
endmodule
`default_nettype wire
